// [logic/fcl_fuse_config_loader.sv]
`timescale 1ns/1ps
`include "fcl_cfg.svh"
// Notes on behaviour
// - CPU reads fuses; only debug port writes
// - Fuses readable from power-up, before copy
// - Copy fuse fields to targets at start-up end
// - New fuse values act only after reset; lock byte and system bit 0 act at once
// - Watchdog window and period from fuse nibbles
// - Brown-out level from bits 7:5
// - Brown-out sample rate from bit 4
// - Brown-out active mode from bits 3:2
// - Brown-out sleep mode from bits 1:0
// - Calibration lock from oscillator bit 7
// - Frequency select picks calibration bytes
// - CRC region from system bits 7:6
// - Reset pin function from bit 3
// - EEPROM kept on erase if system bit 0 set, unless locked
// - Four read-only oscillator error bytes
module fcl_fuse_config_loader (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [87:0] fuse_init,
  input wire logic fuse_init_load,
  input wire logic [7:0] cal16_byte,
  input wire logic [7:0] tcal16_byte,
  input wire logic [7:0] cal20_byte,
  input wire logic [7:0] tcal20_byte,
  input wire logic [31:0] osc_error_bytes,
  input wire logic [5:0] cpu_addr,
  input wire logic cpu_rd,
  input wire logic cpu_wr,
  input wire logic [7:0] cpu_wdata,
  output logic [7:0] cpu_rdata,
  input wire logic [5:0] dbg_addr,
  input wire logic dbg_rd,
  input wire logic dbg_wr,
  input wire logic [7:0] dbg_wdata,
  output logic [7:0] dbg_rdata,
  output logic cpu_reset_hold,
  output logic [3:0] watchdog_window,
  output logic [3:0] watchdog_period,
  output logic [2:0] brownout_threshold_level,
  output logic brownout_sample_rate,
  output logic [1:0] brownout_active_mode,
  output logic [1:0] brownout_sleep_mode,
  output logic calibration_lock,
  output logic [1:0] osc_frequency_select,
  output logic [6:0] osc_calibration_field,
  output logic [3:0] osc_temp_calibration_field,
  output logic [1:0] crc_region_select,
  output logic reset_pin_function,
  input wire logic chip_erase,
  output logic eeprom_erase
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    fcl_pkg::fcl_state_type phase;
    logic [3:0] wdt_win;
    logic [3:0] wdt_per;
    logic [2:0] bod_lvl;
    logic bod_samp;
    logic [1:0] bod_act;
    logic [1:0] bod_slp;
    logic osc_lock;
    logic [1:0] fsel;
    logic [6:0] cal;
    logic [3:0] tcal;
    fcl_pkg::fcl_crc_type crc;
    logic rst_pin;
    logic [7:0] cpu_rdata;
    logic [7:0] dbg_rdata;
    logic ee_erase;
  } fcl_state_type;

  fcl_state_type state_reg;
  fcl_state_type state_next;
  logic [7:0] wdt_f;
  logic [7:0] bod_f;
  logic [7:0] osc_f;
  logic [7:0] sys_f;
  logic [7:0] cpu_byte;
  logic [7:0] dbg_byte;

  fcl_store_if st ();

  // ----------------------------------------
  // Fuse storage; the debug port is the sole writer
  // ----------------------------------------
  assign st.wr_en = dbg_wr;
  assign st.wr_addr = dbg_addr;
  assign st.wr_data = dbg_wdata;
  // The loader taps the image directly, so the read port is the CPU's at all times
  assign st.rd_addr = cpu_addr;

  fcl_fuse_store u_store (
    .clk(clk),
    .ce(ce),
    .fuse_init(fuse_init),
    .load_init(fuse_init_load),
    .st(st)
  );

  // Loader taps the stored image directly (watchdog byte from fuse_init during load); the shared read port serves the CPU
  assign wdt_f = fuse_init_load ? fuse_init[7:0] : u_store.state_reg.fuse[`FCL_OFF_WDT];
  assign bod_f = u_store.state_reg.fuse[`FCL_OFF_BOD];
  assign osc_f = u_store.state_reg.fuse[`FCL_OFF_OSC];
  assign sys_f = u_store.state_reg.fuse[`FCL_OFF_SYSA];

  // ----------------------------------------
  // Read decode, shared by both readers
  // ----------------------------------------
  function automatic logic [7:0] fcl_read(input logic [5:0] a, input logic [7:0] fuse_byte,
                                          input logic fuse_hit);
    logic [7:0] r;
    r = 8'h00;
    if (fuse_hit) begin
      r = fuse_byte;
    end else begin
      unique case (a)
        `FCL_OFF_CAL16: r = {1'b0, cal16_byte[6:0]};
        `FCL_OFF_TCAL16: r = {4'h0, tcal16_byte[3:0]};
        `FCL_OFF_CAL20: r = {1'b0, cal20_byte[6:0]};
        `FCL_OFF_TCAL20: r = {4'h0, tcal20_byte[3:0]};
        `FCL_OFF_E16LO: r = osc_error_bytes[7:0];
        `FCL_OFF_E16HI: r = osc_error_bytes[15:8];
        `FCL_OFF_E20LO: r = osc_error_bytes[23:16];
        `FCL_OFF_E20HI: r = osc_error_bytes[31:24];
        default: r = 8'h00;
      endcase
    end
    return r;
  endfunction

  // Fuse reads need no copy first, so CPU sees fuses from power-up
  assign cpu_byte = fcl_read(cpu_addr, st.rd_data, st.rd_hit);
  assign dbg_byte = fcl_read(dbg_addr, u_store.state_reg.fuse[dbg_addr[3:0]],
                             (dbg_addr <= `FCL_OFF_LOCK));

  // ----------------------------------------
  // Start-up copy and run
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    if (cpu_rd) begin
      state_next.cpu_rdata = cpu_byte;
    end
    // Locked device hides fuse data from the debug port
    if (dbg_rd) begin
      state_next.dbg_rdata = st.locked ? 8'h00 : dbg_byte;
    end
    // cpu_wr and cpu_wdata are accepted and dropped with no effect
    state_next.ee_erase = chip_erase && (st.locked || !sys_f[`FCL_EEPROM_KEEP_ON_ERASE_BIT]);
    unique case (state_reg.phase)
      fcl_pkg::FCL_IDLE: begin
        state_next.phase = fcl_pkg::FCL_LOAD;
      end
      fcl_pkg::FCL_LOAD: begin
        // Single copy pass; targets are never touched again until reset
        state_next.wdt_win = wdt_f[`FCL_WIN_MSB:`FCL_WIN_LSB];
        state_next.wdt_per = wdt_f[`FCL_PER_MSB:`FCL_PER_LSB];
        state_next.bod_lvl = bod_f[`FCL_LVL_MSB:`FCL_LVL_LSB];
        state_next.bod_samp = bod_f[`FCL_SAMP_BIT];
        state_next.bod_act = bod_f[`FCL_ACT_MSB:`FCL_ACT_LSB];
        state_next.bod_slp = bod_f[`FCL_SLP_MSB:`FCL_SLP_LSB];
        state_next.osc_lock = osc_f[`FCL_CALIBRATION_LOCK_BIT];
        state_next.fsel = osc_f[`FCL_FSEL_MSB:`FCL_FSEL_LSB];
        // Reserved codes fall back to the 20 MHz table
        if (osc_f[`FCL_FSEL_MSB:`FCL_FSEL_LSB] == `FCL_FSEL_16) begin
          state_next.cal = cal16_byte[6:0];
          state_next.tcal = tcal16_byte[3:0];
        end else begin
          state_next.cal = cal20_byte[6:0];
          state_next.tcal = tcal20_byte[3:0];
        end
        state_next.crc = fcl_pkg::fcl_crc_type'(sys_f[`FCL_CRC_MSB:`FCL_CRC_LSB]);
        state_next.rst_pin = sys_f[`FCL_RSTPIN_BIT];
        state_next.phase = fcl_pkg::FCL_RUN;
      end
      fcl_pkg::FCL_RUN: begin
        state_next.phase = fcl_pkg::FCL_RUN;
      end
      default: begin
        state_next.phase = fcl_pkg::FCL_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= '0;
      state_reg.phase <= fcl_pkg::FCL_IDLE;
      state_reg.crc <= fcl_pkg::fcl_crc_type'(`FCL_RST_CRC);
      state_reg.rst_pin <= `FCL_RST_RSTPIN;
      // Read ports keep serving during reset, since fuses are valid before the copy
      state_reg.cpu_rdata <= ce ? state_next.cpu_rdata : state_reg.cpu_rdata;
      state_reg.dbg_rdata <= ce ? state_next.dbg_rdata : state_reg.dbg_rdata;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign cpu_reset_hold = state_reg.phase != fcl_pkg::FCL_RUN;
  assign cpu_rdata = state_reg.cpu_rdata;
  assign dbg_rdata = state_reg.dbg_rdata;
  assign watchdog_window = state_reg.wdt_win;
  assign watchdog_period = state_reg.wdt_per;
  assign brownout_threshold_level = state_reg.bod_lvl;
  assign brownout_sample_rate = state_reg.bod_samp;
  assign brownout_active_mode = state_reg.bod_act;
  assign brownout_sleep_mode = state_reg.bod_slp;
  assign calibration_lock = state_reg.osc_lock;
  assign osc_frequency_select = state_reg.fsel;
  assign osc_calibration_field = state_reg.cal;
  assign osc_temp_calibration_field = state_reg.tcal;
  assign crc_region_select = state_reg.crc;
  assign reset_pin_function = state_reg.rst_pin;
  assign eeprom_erase = state_reg.ee_erase;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_copy_window: assert property (@(posedge clk) disable iff (srst)
    (ce && state_reg.phase == fcl_pkg::FCL_LOAD) |=>
      watchdog_window == $past(wdt_f[7:4]) && watchdog_period == $past(wdt_f[3:0]))
    else $error("watchdog fields not copied");
  a_copy_bod: assert property (@(posedge clk) disable iff (srst)
    (ce && state_reg.phase == fcl_pkg::FCL_LOAD) |=>
      {brownout_threshold_level, brownout_sample_rate, brownout_active_mode,
       brownout_sleep_mode} == $past(bod_f))
    else $error("brown-out fields not copied");
  a_hold_after_copy: assert property (@(posedge clk) disable iff (srst)
    (state_reg.phase == fcl_pkg::FCL_RUN && $past(state_reg.phase) == fcl_pkg::FCL_RUN)
      |-> $stable(watchdog_window) && $stable(crc_region_select) && $stable(osc_calibration_field))
    else $error("target changed without reset");
  a_release_time: assert property (@(posedge clk)
    srst ##1 (!srst && ce) ##1 (!srst && ce) |=> !cpu_reset_hold)
    else $error("processor not released after copy");
  a_hold_in_copy: assert property (@(posedge clk) disable iff (srst)
    (state_reg.phase != fcl_pkg::FCL_RUN) |-> cpu_reset_hold)
    else $error("processor released before copy");
  a_cal_pick: assert property (@(posedge clk) disable iff (srst)
    (ce && state_reg.phase == fcl_pkg::FCL_LOAD && osc_f[1:0] == `FCL_FSEL_16)
      |=> osc_calibration_field == $past(cal16_byte[6:0]))
    else $error("16 MHz calibration not chosen");
  a_erase_lock: assert property (@(posedge clk) disable iff (srst)
    (ce && chip_erase && st.locked) |=> eeprom_erase)
    else $error("locked erase kept eeprom");
  a_cpu_no_write: assert property (@(posedge clk) disable iff (srst)
    (ce && cpu_wr && !dbg_wr && !fuse_init_load) |=> $stable(u_store.state_reg))
    else $error("cpu write changed fuses");
  a_sys_copy: assert property (@(posedge clk) disable iff (srst)
    (ce && state_reg.phase == fcl_pkg::FCL_LOAD) |=>
      reset_pin_function == $past(sys_f[3]) && crc_region_select == $past(sys_f[7:6]))
    else $error("system fields not copied");
endmodule

// [pkg/fcl_cfg.svh]
`ifndef FCL_CFG_SVH
`define FCL_CFG_SVH
// ----------------------------------------
// Fuse offsets
// ----------------------------------------
`define FCL_OFF_WDT 6'h00
`define FCL_OFF_BOD 6'h01
`define FCL_OFF_OSC 6'h02
`define FCL_OFF_SYSA 6'h05
`define FCL_OFF_SYSB 6'h06
`define FCL_OFF_APP_CODE_END_FUSE 6'h07
`define FCL_OFF_BOOT_SECTION_END_FUSE 6'h08
`define FCL_OFF_LOCK 6'h0a
// ----------------------------------------
// Signature row offsets
// ----------------------------------------
`define FCL_OFF_CAL16 6'h18
`define FCL_OFF_TCAL16 6'h19
`define FCL_OFF_CAL20 6'h1a
`define FCL_OFF_TCAL20 6'h1b
`define FCL_OFF_E16LO 6'h22
`define FCL_OFF_E16HI 6'h23
`define FCL_OFF_E20LO 6'h24
`define FCL_OFF_E20HI 6'h25
// ----------------------------------------
// Field positions and codes
// ----------------------------------------
`define FCL_WIN_MSB 7
`define FCL_WIN_LSB 4
`define FCL_PER_MSB 3
`define FCL_PER_LSB 0
`define FCL_LVL_MSB 7
`define FCL_LVL_LSB 5
`define FCL_SAMP_BIT 4
`define FCL_ACT_MSB 3
`define FCL_ACT_LSB 2
`define FCL_SLP_MSB 1
`define FCL_SLP_LSB 0
`define FCL_CALIBRATION_LOCK_BIT 7
`define FCL_FSEL_MSB 1
`define FCL_FSEL_LSB 0
`define FCL_FSEL_16 2'h1
`define FCL_FSEL_20 2'h2
`define FCL_CRC_MSB 7
`define FCL_CRC_LSB 6
`define FCL_RSTPIN_BIT 3
`define FCL_EEPROM_KEEP_ON_ERASE_BIT 0
`define FCL_OPEN_KEY 8'hc5
// ----------------------------------------
// Reset values
// ----------------------------------------
`define FCL_RST_BYTE 8'h00
`define FCL_RST_CRC 2'h3
`define FCL_RST_RSTPIN 1'b1
`endif

// [pkg/fcl_pkg.sv]
package fcl_pkg;
  typedef enum logic [1:0] {
    FCL_IDLE = 2'b00,
    FCL_LOAD = 2'b01,
    FCL_RUN = 2'b10
  } fcl_state_type;

  typedef enum logic [1:0] {
    FCL_CRC_ALL = 2'b00,
    FCL_CRC_BOOT = 2'b01,
    FCL_CRC_BOOTAPP = 2'b10,
    FCL_CRC_NONE = 2'b11
  } fcl_crc_type;
endpackage

// [pkg/fcl_store_if.sv]
`timescale 1ns/1ps
interface fcl_store_if;
  logic [5:0] rd_addr;
  logic [7:0] rd_data;
  logic rd_hit;
  logic wr_en;
  logic [5:0] wr_addr;
  logic [7:0] wr_data;
  logic locked;
  modport owner (input rd_addr, output rd_data, output rd_hit,
                 input wr_en, input wr_addr, input wr_data, output locked);
  modport user (output rd_addr, input rd_data, input rd_hit,
                output wr_en, output wr_addr, output wr_data, input locked);
endinterface

// [logic/fcl_fuse_store.sv]
`timescale 1ns/1ps
`include "fcl_cfg.svh"
module fcl_fuse_store (
  input wire logic clk,
  input wire logic ce,
  input wire logic [87:0] fuse_init,
  input wire logic load_init,
  fcl_store_if.owner st
);
  // ----------------------------------------
  // Fuse bytes 0x00..0x0a; nonvolatile image is preset by load_init
  // ----------------------------------------
  typedef struct packed {
    logic [10:0][7:0] fuse;
  } fcl_store_state_type;

  fcl_store_state_type state_reg;
  fcl_store_state_type state_next;

  function automatic logic fcl_is_fuse(input logic [5:0] a);
    return (a <= `FCL_OFF_LOCK) && (a != 6'h03) && (a != 6'h04) && (a != 6'h09);
  endfunction

  always_comb begin
    state_next = state_reg;
    if (load_init) begin
      state_next.fuse = fuse_init;
    end else if (st.wr_en && fcl_is_fuse(st.wr_addr)) begin
      // Only the debug port reaches this write path
      state_next.fuse[st.wr_addr[3:0]] = st.wr_data;
    end
  end

  // No reset: fuse contents survive system reset and are valid from power-up
  always_ff @(posedge clk) begin
    if (ce) begin
      state_reg <= state_next;
    end
  end

  assign st.rd_hit = fcl_is_fuse(st.rd_addr);
  assign st.rd_data = st.rd_hit ? state_reg.fuse[st.rd_addr[3:0]] : `FCL_RST_BYTE;
  assign st.locked = state_reg.fuse[`FCL_OFF_LOCK] != `FCL_OPEN_KEY;
endmodule

// [sim/fcl_prog_model.sv]
`timescale 1ns/1ps
// ----------------------------------------
// Programming and debug port model
// ----------------------------------------
module fcl_prog_model (
  input wire logic clk,
  output logic [5:0] dbg_addr,
  output logic dbg_rd,
  output logic dbg_wr,
  output logic [7:0] dbg_wdata,
  input wire logic [7:0] dbg_rdata
);
  initial begin
    dbg_addr = 6'h00;
    dbg_rd = 1'b0;
    dbg_wr = 1'b0;
    dbg_wdata = 8'h00;
  end

  // Reserved fuse bits, always sent as ones
  function automatic logic [7:0] rsv(input logic [5:0] a);
    case (a)
      6'h02: rsv = 8'h7c;
      6'h05: rsv = 8'h36;
      6'h06: rsv = 8'hf8;
      default: rsv = 8'h00;
    endcase
  endfunction

  task automatic write_fuse(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    dbg_addr <= a;
    dbg_wdata <= d | rsv(a);
    dbg_wr <= 1'b1;
    @(posedge clk);
    dbg_wr <= 1'b0;
    // Released data lines must not keep showing the last byte
    dbg_wdata <= ~(d | rsv(a));
  endtask

  task automatic read_fuse(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk);
    dbg_addr <= a;
    dbg_rd <= 1'b1;
    @(posedge clk);
    dbg_rd <= 1'b0;
    #1 d = dbg_rdata;
  endtask
endmodule

// [sim/fcl_fuse_config_loader_tb_top.sv]
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin fail_count++; \
  $display("wrong value at %0t: got %h exp %h", $time, a, e); end end
module fcl_fuse_config_loader_tb_top;
  logic clk, srst, ce, fuse_init_load, cpu_rd, cpu_wr, dbg_rd, dbg_wr;
  logic [87:0] fuse_init;
  logic [7:0] cal16_byte, tcal16_byte, cal20_byte, tcal20_byte;
  logic [31:0] osc_error_bytes;
  logic [5:0] cpu_addr, dbg_addr;
  logic [7:0] cpu_wdata, cpu_rdata, dbg_wdata, dbg_rdata;
  logic cpu_reset_hold, brownout_sample_rate, calibration_lock, reset_pin_function;
  logic [3:0] watchdog_window, watchdog_period, osc_temp_calibration_field;
  logic [2:0] brownout_threshold_level;
  logic [1:0] brownout_active_mode, brownout_sleep_mode, osc_frequency_select;
  logic [1:0] crc_region_select;
  logic [6:0] osc_calibration_field;
  logic chip_erase, eeprom_erase;
  int fail_count, comparisons, cycles;
  logic [7:0] d, w, b, o, s, pw, pb, po, ps;
  logic [2:0] lvl_tab [4];

  fcl_fuse_config_loader u_dut (.*);
  fcl_prog_model u_prog (.clk(clk), .dbg_addr(dbg_addr), .dbg_rd(dbg_rd),
    .dbg_wr(dbg_wr), .dbg_wdata(dbg_wdata), .dbg_rdata(dbg_rdata));

  // ----------------------------------------
  // Clock, timeout and verdict
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic stop_test();
    if (fail_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // The whole sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      stop_test();
    end
  end

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic cpu_read(input logic [5:0] a, output logic [7:0] q);
    @(posedge clk);
    cpu_addr <= a;
    cpu_rd <= 1'b1;
    @(posedge clk);
    cpu_rd <= 1'b0;
    #1 q = cpu_rdata;
  endtask

  task automatic cpu_write(input logic [5:0] a, input logic [7:0] v);
    @(posedge clk);
    cpu_addr <= a;
    cpu_wdata <= v;
    cpu_wr <= 1'b1;
    @(posedge clk);
    cpu_wr <= 1'b0;
  endtask

  // Copy has no completion strobe other than the hold flag, so wait on it
  task automatic do_reset();
    @(posedge clk);
    srst <= 1'b1;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 10 && cpu_reset_hold !== 1'b0; i++) begin
      @(posedge clk);
      #1;
    end
    `CHK(cpu_reset_hold, 1'b0)
  endtask

  task automatic erase_check(input logic e);
    @(posedge clk);
    chip_erase <= 1'b1;
    @(posedge clk);
    #1 `CHK(eeprom_erase, e)
    @(posedge clk);
    chip_erase <= 1'b0;
  endtask

  task automatic check_cfg(input logic [7:0] w, b, o, s);
    logic f16;
    f16 = (o[1:0] == 2'h1);
    `CHK(watchdog_window, w[7:4])
    `CHK(watchdog_period, w[3:0])
    `CHK(brownout_threshold_level, b[7:5])
    `CHK(brownout_sample_rate, b[4])
    `CHK(brownout_active_mode, b[3:2])
    `CHK(brownout_sleep_mode, b[1:0])
    `CHK(calibration_lock, o[7])
    `CHK(osc_frequency_select, o[1:0])
    `CHK(osc_calibration_field, f16 ? cal16_byte[6:0] : cal20_byte[6:0])
    `CHK(osc_temp_calibration_field, f16 ? tcal16_byte[3:0] : tcal20_byte[3:0])
    `CHK(crc_region_select, s[7:6])
    `CHK(reset_pin_function, s[3])
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    fail_count = 0;
    comparisons = 0;
    cycles = 0;
    srst = 1'b1;
    ce = 1'b1;
    fuse_init_load = 1'b0;
    fuse_init = {8'hc5, 8'hff, 8'h00, 8'h00, 8'hf8, 8'he4, 8'hff, 8'hff, 8'h02, 8'h00, 8'h5a};
    cal16_byte = 8'h2b;
    tcal16_byte = 8'h09;
    cal20_byte = 8'h51;
    tcal20_byte = 8'h06;
    osc_error_bytes = 32'h0cf3_05fa;
    {cpu_addr, cpu_rd, cpu_wr, cpu_wdata, chip_erase} = '0;
    lvl_tab = '{3'h0, 3'h2, 3'h7, 3'h2};
    @(posedge clk);
    fuse_init_load <= 1'b1;
    @(posedge clk);
    fuse_init_load <= 1'b0;
    cpu_read(6'h00, d);
    `CHK(d, 8'h5a)
    cpu_read(6'h05, d);
    `CHK(d, 8'he4)
    do_reset();
    pw = 8'h5a;
    pb = 8'h00;
    po = 8'h02;
    ps = 8'he4;
    check_cfg(pw, pb, po, ps);
    erase_check(1'b1);
    for (int i = 0; i < 4; i++) begin
      cpu_read(6'h22 + 6'(i), d);
      `CHK(d, osc_error_bytes[8*i +: 8])
    end
    cpu_write(6'h00, 8'h33);
    cpu_write(6'h24, 8'h33);
    cpu_read(6'h00, d);
    `CHK(d, 8'h5a)
    cpu_read(6'h24, d);
    `CHK(d, osc_error_bytes[23:16])
    u_prog.read_fuse(6'h00, d);
    `CHK(d, 8'h5a)
    for (int k = 0; k < 4; k++) begin
      w = {4'(k + 3), 4'(12 - k)};
      b = {lvl_tab[k], k[0], k[1:0], k[1:0]};
      o = {k[1], 5'h00, k[0] ? 2'h1 : 2'h2};
      s = {k[1:0], 2'b00, ~k[0], 2'b00, k[0]};
      u_prog.write_fuse(6'h00, w);
      u_prog.write_fuse(6'h01, b);
      u_prog.write_fuse(6'h02, o);
      u_prog.write_fuse(6'h05, s);
      check_cfg(pw, pb, po, ps);
      do_reset();
      check_cfg(w, b, o, s);
      erase_check(~s[0]);
      pw = w;
      pb = b;
      po = o;
      ps = s;
    end
    u_prog.write_fuse(6'h0a, 8'h00);
    do_reset();
    erase_check(1'b1);
    u_prog.read_fuse(6'h00, d);
    `CHK(d, 8'h00)
    cpu_read(6'h00, d);
    `CHK(d, pw)
    stop_test();
  end
endmodule
